// ### hdl/hcm_pkg.sv
package hcm_pkg;

  // host i/o map (ten-bit pc i/o addresses)
  localparam logic [9:0] HCM_SEG_ADDR  = 10'h2d7; // window segment byte
  localparam logic [9:0] HCM_PARM_ADDR = 10'h2db; // parameter_response
  localparam logic [9:0] HCM_CFG_ADDR  = 10'h2dc; // interface_configuration

  // interface_configuration field positions
  localparam int HCM_CFG_PROTO_BIT   = 0; // 1 twinax, 0 coax/twisted pair
  localparam int HCM_CFG_THIRD_BIT   = 1; // third-party host interface mode
  localparam int HCM_CFG_VENDOR_BIT  = 2; // mainframe-vendor host interface mode
  localparam int HCM_CFG_ATTR_BUF_BIT = 3; // extended attribute buffer enable
  localparam int HCM_CFG_MUX_BIT     = 4; // multiplexed coax station mode
  localparam int HCM_CFG_PENDING_BIT = 7; // request pending, cleared by firmware

  // reset values
  localparam logic [7:0] HCM_CFG_RST  = 8'h00;
  localparam logic [7:0] HCM_PARM_RST = 8'h00;
  localparam logic [7:0] HCM_SEG_RST  = 8'hce; // default window segment
  localparam logic [7:0] HCM_UNMAPPED = 8'h00; // read value off the map

  // index of the shared byte registers inside the register bank
  localparam int HCM_IDX_PARM = 0;
  localparam int HCM_IDX_CFG  = 1;
  localparam int HCM_NREGS    = 2;

  // host i/o read sequencing
  typedef enum logic [0:0] {
    HCM_RD_IDLE,
    HCM_RD_DONE
  } hcm_rd_state_t;

endpackage

// ### hdl/hcm_regbank.sv
`timescale 1ns/1ps
`default_nettype none

// byte registers written from two sides; read data come out of flops
module hcm_regbank
  import hcm_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [HCM_NREGS-1:0] host_we_i,
  input  wire logic [7:0]           host_wdata_i,
  input  wire logic [HCM_NREGS-1:0] proc_we_i,
  input  wire logic [7:0]           proc_wdata_i,
  output logic      [7:0]           rd_parm_o,
  output logic      [7:0]           rd_cfg_o
);

  logic [7:0] mem_q [HCM_NREGS];  // stored bytes
  logic [7:0] mem_d [HCM_NREGS];  // next stored bytes

  // reset value by index
  function automatic logic [7:0] rst_val(input int idx);
    return (idx == HCM_IDX_CFG) ? HCM_CFG_RST : HCM_PARM_RST;
  endfunction

  genvar g;
  generate
    for (g = 0; g < HCM_NREGS; g++) begin : g_reg
      // latest writer wins; processor last in the same cycle,
      // except that a host pending set survives a firmware clear
      always_comb begin
        mem_d[g] = mem_q[g];
        if (host_we_i[g]) begin
          mem_d[g] = host_wdata_i;
        end
        if (proc_we_i[g]) begin
          mem_d[g] = proc_wdata_i;
          if (g == HCM_IDX_CFG && host_we_i[g]) begin
            mem_d[g][HCM_CFG_PENDING_BIT] = host_wdata_i[HCM_CFG_PENDING_BIT];
          end
        end
      end

      // storage only
      always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
          mem_q[g] <= rst_val(g);
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
    end
  endgenerate

  assign rd_parm_o = mem_q[HCM_IDX_PARM];
  assign rd_cfg_o  = mem_q[HCM_IDX_CFG];

endmodule

`default_nettype wire

// ### hdl/hcm_mailbox.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - host config write raises processor interrupt request
// - lockout plus pending interrupt stalls host accesses
// - firmware clears pending, writes back implemented config
// - protocol bit selects twinax or coax mode
// - separate third-party and vendor mode bits
// - dedicated bit enables extended attribute buffer
// - mux bit selects station mode, address from parameter
// - config register accepts any raw host byte
// - segment register at own address enables window
module hcm_mailbox
  import hcm_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // host pc i/o side
  input  wire logic [9:0] io_addr_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  output logic            io_rvalid_o,
  output logic            io_wait_o,
  input  wire logic       host_mem_req_i,
  output logic            host_mem_ack_o,
  // embedded processor side
  input  wire logic       host_lockout_en_i,
  input  wire logic       proc_irq_clr_i,
  input  wire logic       proc_cfg_wr_i,
  input  wire logic [7:0] proc_cfg_data_i,
  input  wire logic       proc_parm_wr_i,
  input  wire logic [7:0] proc_parm_data_i,
  output logic            host_to_processor_irq_o,
  output logic      [7:0] proc_cfg_o,
  output logic      [7:0] proc_parm_o,
  // dual-port window
  output logic            window_enable_o,
  output logic      [7:0] window_segment_byte_o,
  // decoded interface modes
  output logic            twinax_mode_o,
  output logic            coax_mode_o,
  output logic            third_party_mode_o,
  output logic            third_party_variant_o,
  output logic            vendor_mode_o,
  output logic            extended_attribute_buffer_enable_o,
  output logic            mux_station_mode_o,
  output logic      [7:0] mux_station_addr_o
);

  // registered state first, each with its next value beside it
  logic                 irq_q, irq_d;           // request toward processor
  logic                 win_en_q, win_en_d;     // window enabled by segment write
  logic [7:0]           seg_q, seg_d;           // window segment byte
  logic [7:0]           rdata_q, rdata_d;       // host read data
  hcm_rd_state_t        rd_q, rd_d;             // read answer state
  // combinational helpers
  logic [7:0]           cfg_rd, parm_rd;        // bank outputs
  logic                 stall;                  // host held off
  logic                 wr_ok, rd_ok;           // accepted host cycles
  logic [HCM_NREGS-1:0] host_we, proc_we;       // bank write strobes

  // address match, shared by read and write decode;
  // full ten-bit compare, so aliases higher up never hit
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    return a == r;
  endfunction

  // lockout: while firmware has it on and the request is outstanding,
  // every host access waits; no timeout, since a halted cpu never clears
  assign stall     = host_lockout_en_i & irq_q;
  // wait only while the host actually presents a cycle
  assign io_wait_o = stall & (io_wr_i | io_rd_i);
  // memory window answers in the same cycle unless held off
  assign host_mem_ack_o = host_mem_req_i & ~stall;
  // a held strobe is taken on the first edge after the stall lifts;
  // nothing is queued here, the host keeps the cycle up itself
  assign wr_ok     = io_wr_i & ~stall;
  assign rd_ok     = io_rd_i & ~stall;

  // host writes store the raw byte, nothing filtered;
  // the device never forces the pending bit, firmware judges the byte
  // an unmapped address decodes to no strobe and is dropped
  always_comb begin
    host_we = '0;
    // station address or any other parameter byte
    host_we[HCM_IDX_PARM] = wr_ok & hit(io_addr_i, HCM_PARM_ADDR);
    host_we[HCM_IDX_CFG]  = wr_ok & hit(io_addr_i, HCM_CFG_ADDR);
    // firmware strobes pass straight through
    proc_we = '0;
    proc_we[HCM_IDX_PARM] = proc_parm_wr_i;
    proc_we[HCM_IDX_CFG]  = proc_cfg_wr_i;
  end

  // both shared bytes live in the bank; its outputs are flops,
  // so host reads, firmware view and mode decode agree every cycle
  hcm_regbank u_bank (
    .mclk_i       (mclk_i),
    .sys_rst_i    (sys_rst_i),
    .host_we_i    (host_we),
    .host_wdata_i (io_wdata_i),
    .proc_we_i    (proc_we),
    .proc_wdata_i (proc_cfg_wr_i ? proc_cfg_data_i : proc_parm_data_i),
    .rd_parm_o    (parm_rd),
    .rd_cfg_o     (cfg_rd)
  );

  // a shared data input would mix bytes if both firmware strobes fire;
  // firmware writes one register per cycle

  // interrupt, segment and window next state;
  // the set is written after the clear so that a host request landing
  // in the firmware's clear cycle is not lost
  always_comb begin
    irq_d    = irq_q;
    seg_d    = seg_q;
    win_en_d = win_en_q;
    if (proc_irq_clr_i) begin
      irq_d = 1'b0;
    end
    if (host_we[HCM_IDX_CFG]) begin
      irq_d = 1'b1;  // set beats clear
    end
    // segment write opens the window; only reset closes it again.
    // odd segment values are stored as given, the host must avoid them
    if (wr_ok && hit(io_addr_i, HCM_SEG_ADDR)) begin
      seg_d    = io_wdata_i;
      win_en_d = 1'b1;
    end
  end

  // registers only; reset leaves the window closed at segment ce
  // irq level goes straight out, so the processor sees a clean flop
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_q    <= 1'b0;
      seg_q    <= HCM_SEG_RST;
      win_en_q <= 1'b0;
    end else begin
      irq_q    <= irq_d;
      seg_q    <= seg_d;
      win_en_q <= win_en_d;
    end
  end

  // host read: data one cycle after the accepted strobe;
  // rdata holds after the pulse, so a slow host may still look at it
  // reading has no side effect on any register
  always_comb begin
    rdata_d = rdata_q;
    rd_d    = HCM_RD_IDLE;
    if (rd_ok) begin
      rd_d = HCM_RD_DONE;
      // at most one address can match; order is immaterial
      case (1'b1)
        hit(io_addr_i, HCM_CFG_ADDR):  rdata_d = cfg_rd;
        hit(io_addr_i, HCM_PARM_ADDR): rdata_d = parm_rd;
        hit(io_addr_i, HCM_SEG_ADDR):  rdata_d = seg_q;
        default:                       rdata_d = HCM_UNMAPPED;
      endcase
    end
  end

  // registers only; no answer pending out of reset
  // rdata resets to zero, the same byte an unmapped read returns
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
      rd_q    <= HCM_RD_IDLE;
    end else begin
      rdata_q <= rdata_d;
      rd_q    <= rd_d;
    end
  end

  // valid decodes the answer state: one cycle per accepted read
  // kept as a state so the pulse comes from a flop
  always_comb begin
    case (rd_q)
      HCM_RD_DONE: io_rvalid_o = 1'b1;
      default:     io_rvalid_o = 1'b0;
    endcase
  end

  // firmware sees the very bytes the host reads back
  assign io_rdata_o              = rdata_q;
  assign host_to_processor_irq_o = irq_q;
  assign proc_cfg_o              = cfg_rd;
  assign proc_parm_o             = parm_rd;
  assign window_enable_o         = win_en_q;
  assign window_segment_byte_o   = seg_q;

  // mode decode straight from the stored configuration byte, station address from the parameter byte;
  // bits are passed on as stored, with no check for clashing modes:
  // firmware writes back only what it really runs, so the stored
  // byte is already the implemented mode once pending has cleared
  // the variant output means something only in third-party mode
  assign twinax_mode_o         = cfg_rd[HCM_CFG_PROTO_BIT];
  assign coax_mode_o           = ~cfg_rd[HCM_CFG_PROTO_BIT];
  assign third_party_mode_o    = cfg_rd[HCM_CFG_THIRD_BIT];
  assign third_party_variant_o = cfg_rd[HCM_CFG_THIRD_BIT]
                                 & cfg_rd[HCM_CFG_PROTO_BIT];
  assign vendor_mode_o         = cfg_rd[HCM_CFG_VENDOR_BIT];
  assign extended_attribute_buffer_enable_o = cfg_rd[HCM_CFG_ATTR_BUF_BIT];
  assign mux_station_mode_o    = cfg_rd[HCM_CFG_MUX_BIT];
  assign mux_station_addr_o    = parm_rd;

endmodule

`default_nettype wire

// ### tb/hcm_mailbox_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watch on stall, write effects and mode decode
module hcm_mailbox_checker
  import hcm_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic [9:0] io_addr_i,
  input wire logic       io_wr_i,
  input wire logic       io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic       io_rvalid_o,
  input wire logic       io_wait_o,
  input wire logic       host_mem_req_i,
  input wire logic       host_mem_ack_o,
  input wire logic       host_lockout_en_i,
  input wire logic       proc_cfg_wr_i,
  input wire logic [7:0] proc_cfg_data_i,
  input wire logic       host_to_processor_irq_o,
  input wire logic [7:0] proc_cfg_o,
  input wire logic       window_enable_o,
  input wire logic [7:0] window_segment_byte_o,
  input wire logic       twinax_mode_o,
  input wire logic       coax_mode_o,
  input wire logic       third_party_variant_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic stall = host_lockout_en_i & host_to_processor_irq_o; // lockout in force
  wire logic wr_ok = io_wr_i & ~io_wait_o;                      // write taken
  wire logic cfg_wr = wr_ok & (io_addr_i == HCM_CFG_ADDR);        // host config write
  a_cfg_write_irq: assert property (cfg_wr |=> host_to_processor_irq_o)
    else $error("config write left irq low");
  a_stall_holds_io: assert property ((io_wr_i || io_rd_i) && stall |-> io_wait_o)
    else $error("host access not stalled");
  a_wait_only_stall: assert property (io_wait_o |-> stall && (io_wr_i || io_rd_i))
    else $error("stall without cause");
  a_mem_ack_gate: assert property (host_mem_req_i |-> host_mem_ack_o == !stall)
    else $error("memory ack wrong under lockout");
  a_fw_writeback: assert property (proc_cfg_wr_i && !cfg_wr |=>
    proc_cfg_o == $past(proc_cfg_data_i)) else $error("firmware byte not stored");
  a_host_raw_byte: assert property (cfg_wr && !proc_cfg_wr_i |=>
    proc_cfg_o == $past(io_wdata_i)) else $error("host byte not stored");
  a_proto_decode: assert property (twinax_mode_o == proc_cfg_o[HCM_CFG_PROTO_BIT]
    && coax_mode_o != twinax_mode_o) else $error("protocol decode wrong");
  a_variant_decode: assert property (third_party_variant_o ==
    (proc_cfg_o[HCM_CFG_THIRD_BIT] & proc_cfg_o[HCM_CFG_PROTO_BIT]))
    else $error("variant decode wrong");
  a_read_answer: assert property (io_rd_i && !io_wait_o |=> io_rvalid_o)
    else $error("read not answered");
  a_seg_window: assert property (wr_ok && io_addr_i == HCM_SEG_ADDR |=> window_enable_o
    && window_segment_byte_o == $past(io_wdata_i)) else $error("segment write lost");
  c_irq: cover property ($rose(host_to_processor_irq_o));
  c_stall: cover property (io_wait_o);
  c_window: cover property ($rose(window_enable_o));
endmodule
bind hcm_mailbox hcm_mailbox_checker u_chk (.mclk_i, .sys_rst_i, .io_addr_i, .io_wr_i,
  .io_rd_i, .io_wdata_i, .io_rvalid_o, .io_wait_o, .host_mem_req_i, .host_mem_ack_o,
  .host_lockout_en_i, .proc_cfg_wr_i, .proc_cfg_data_i, .host_to_processor_irq_o,
  .proc_cfg_o, .window_enable_o, .window_segment_byte_o, .twinax_mode_o, .coax_mode_o,
  .third_party_variant_o);
`default_nettype wire

// ### tb/hcm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// pc host issuing byte i/o cycles; idle lines carry inverted junk
module hcm_host_model
  import hcm_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       io_wait_i,
  output var  logic [9:0] io_addr_o,
  output var  logic       io_wr_o,
  output var  logic       io_rd_o,
  output var  logic [7:0] io_wdata_o
);
  initial begin
    {io_addr_o, io_wr_o, io_rd_o, io_wdata_o} = '0;
  end
  // one cycle; wait sampled mid-cycle so edge races cannot fool it
  task automatic cycle(input logic [9:0] a, input logic [7:0] d, input logic wr);
    logic w;
    io_addr_o <= a;
    io_wdata_o <= d;
    io_wr_o <= wr;
    io_rd_o <= ~wr;
    do begin
      @(negedge mclk_i);
      w = io_wait_i;
      @(posedge mclk_i);
    end while (w); // held through lockout
    io_addr_o <= ~a;
    io_wdata_o <= ~d;
    {io_wr_o, io_rd_o} <= 2'b00;
    @(posedge mclk_i);
  endtask
  // station byte first, then the request with pending set
  task automatic cfg_request(input logic [7:0] cfg, input logic [7:0] stn);
    cycle(HCM_PARM_ADDR, stn, 1'b1);
    cycle(HCM_CFG_ADDR, cfg | 8'h80, 1'b1);
  endtask
endmodule
`default_nettype wire

// ### tb/hcm_mailbox_test.sv
`timescale 1ns/1ps
`default_nettype none
// host via model, firmware by hand; reads checked from a queue
module hcm_mailbox_test
  import hcm_pkg::*;
;
  logic mclk_i, sys_rst_i, io_wr_i, io_rd_i, io_rvalid_o, io_wait_o, host_mem_req_i;
  logic host_mem_ack_o, host_lockout_en_i, proc_irq_clr_i, proc_cfg_wr_i, proc_parm_wr_i;
  logic host_to_processor_irq_o, window_enable_o, twinax_mode_o, coax_mode_o, vendor_mode_o;
  logic third_party_mode_o, third_party_variant_o, extended_attribute_buffer_enable_o;
  logic mux_station_mode_o;
  logic [9:0] io_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o, proc_cfg_data_i, proc_parm_data_i, proc_cfg_o;
  logic [7:0] proc_parm_o, window_segment_byte_o, mux_station_addr_o, rnd, p, impl;
  logic [7:0] exp_q[$];     // expected read bytes, oldest first
  logic [7:0] presets[4] = '{8'h03, 8'h04, 8'h0a, 8'h10};
  int n_mismatch = 0, checks = 0, cyc = 0;
  hcm_mailbox u_hcm_mailbox (.mclk_i, .sys_rst_i, .io_addr_i, .io_wr_i, .io_rd_i,
    .io_wdata_i, .io_rdata_o, .io_rvalid_o, .io_wait_o, .host_mem_req_i, .host_mem_ack_o,
    .host_lockout_en_i, .proc_irq_clr_i, .proc_cfg_wr_i, .proc_cfg_data_i, .proc_parm_wr_i,
    .proc_parm_data_i, .host_to_processor_irq_o, .proc_cfg_o, .proc_parm_o,
    .window_enable_o, .window_segment_byte_o, .twinax_mode_o, .coax_mode_o,
    .third_party_mode_o, .third_party_variant_o, .vendor_mode_o,
    .extended_attribute_buffer_enable_o, .mux_station_mode_o, .mux_station_addr_o);
  hcm_host_model u_hcm_host_model (.mclk_i, .io_wait_i(io_wait_o), .io_addr_o(io_addr_i),
    .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_hcm_host_model.cycle(a, 8'h00, 1'b0);
  endtask
  // firmware: clear request and store what it implemented
  task automatic fw_ack(input logic [7:0] v);
    proc_irq_clr_i <= 1'b1;
    proc_cfg_wr_i <= 1'b1;
    proc_cfg_data_i <= v;
    @(posedge mclk_i);
    {proc_irq_clr_i, proc_cfg_wr_i} <= 2'b00;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // read answers popped in order; sampled mid-cycle
  always @(negedge mclk_i) begin
    if (io_rvalid_o === 1'b1) chk(exp_q.size() > 0 && io_rdata_o === exp_q.pop_front(), "rdata");
  end
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    {sys_rst_i, host_mem_req_i, host_lockout_en_i, proc_irq_clr_i, proc_cfg_wr_i} = 5'h01 << 4;
    {proc_parm_wr_i, proc_cfg_data_i, proc_parm_data_i} = '0;
    rnd = 8'h08;
    repeat (6) @(posedge mclk_i); // cpu halted, loaded, then started
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(HCM_CFG_ADDR, HCM_CFG_RST);
    rd(HCM_SEG_ADDR, HCM_SEG_RST);
    rd(10'h2d8, HCM_UNMAPPED);
    chk(coax_mode_o === 1'b1 && window_enable_o === 1'b0, "reset state");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      p = (i < 4) ? (presets[i] | 8'h80) : (rnd | 8'h80);
      u_hcm_host_model.cfg_request(p, rnd); // cpu running
      @(negedge mclk_i);
      chk(host_to_processor_irq_o === 1'b1, "irq");
      chk({twinax_mode_o, coax_mode_o, third_party_mode_o, third_party_variant_o} ===
        {p[0], ~p[0], p[1], p[1] & p[0]}, "protocol modes");
      chk({mux_station_mode_o, extended_attribute_buffer_enable_o, vendor_mode_o} ===
        p[4:2] && mux_station_addr_o === rnd, "mux, attribute buffer, vendor");
      @(posedge mclk_i);  // strobes start on a rising edge
      rd(HCM_CFG_ADDR, p);
      impl = {1'b0, p[6:1], ~p[0]};
      fw_ack(impl);
      @(negedge mclk_i);
      chk(host_to_processor_irq_o === 1'b0, "irq clear");
      @(posedge mclk_i);  // strobes start on a rising edge
      rd(HCM_CFG_ADDR, impl);
      rd(HCM_PARM_ADDR, rnd);
    end
    $display("test modes done");
    proc_parm_wr_i <= 1'b1;  // firmware response byte
    proc_parm_data_i <= ~rnd;
    @(posedge mclk_i);
    proc_parm_wr_i <= 1'b0;
    rd(HCM_PARM_ADDR, ~rnd);
    chk(proc_parm_o === ~rnd && mux_station_addr_o === ~rnd, "response byte");
    host_lockout_en_i <= 1'b1;
    host_mem_req_i <= 1'b1;
    u_hcm_host_model.cycle(HCM_CFG_ADDR, 8'h81, 1'b1);
    fork
      rd(HCM_PARM_ADDR, ~rnd);
      begin
        repeat (3) @(negedge mclk_i);
        chk(io_wait_o === 1'b1 && host_mem_ack_o === 1'b0, "no stall");
        @(posedge mclk_i);
        fw_ack(8'h01);
      end
    join
    chk(host_mem_ack_o === 1'b1, "ack after clear");
    $display("test lockout done");
    u_hcm_host_model.cycle(HCM_SEG_ADDR, 8'hcc, 1'b1);
    chk(window_enable_o === 1'b1 && window_segment_byte_o === 8'hcc, "window");
    rd(HCM_SEG_ADDR, 8'hcc);
    $display("test window done");
    repeat (3) @(posedge mclk_i);
    chk(exp_q.size() == 0, "reads unanswered");
    tally_and_finish();
  end
endmodule
`default_nettype wire
